// >>> hs_out_pkg.sv
// Constants, register map and states of the high-speed output channel
package hs_out_pkg;

	// ****************************************
	// Data path geometry
	// ****************************************
	localparam int SLICE_W = 12;
	localparam int WORD_W = 60;
	localparam int SLICES = 5;
	localparam logic [2:0] LAST_SLICE = 3'h4;
	localparam logic [1:0] RANKS = 2'h3;

	// ****************************************
	// Register map (byte offsets)
	// ****************************************
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] START_OFS = 8'h04;
	localparam logic [7:0] LEN_OFS = 8'h08;
	localparam logic [7:0] ADDR_OFS = 8'h0C;

	// ****************************************
	// Control and status bit positions
	// ****************************************
	localparam int CMD_RESET_BIT = 0;
	localparam int CMD_EXIT_BIT = 1;
	localparam int ST_IRQ_BIT = 0;
	localparam int ST_LOCK_BIT = 1;
	localparam int ST_BUSY_BIT = 2;
	localparam int ST_FETCH_BIT = 3;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [31:0] START_RST = 32'h0000_0000;
	localparam logic [31:0] LEN_RST = 32'h0000_0040;

	// ****************************************
	// Output channel control states
	// ****************************************
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_FETCH = 4'b0010,
		ST_LOAD = 4'b0100,
		ST_WAIT = 4'b1000
	} occ_state_t;

endpackage : hs_out_pkg

// >>> hs_out_chan.sv
// High-speed output channel: memory word disassembly and three-rank output buffer
//
// Overview of operation
// RULE_01 - Reset command loads start address, requests word
// RULE_02 - Word arrival clears count, sends word, record
// RULE_03 - Record pulse forwarded to peripheral processor
// RULE_04 - Word pulse loads first rank, then forwarded
// RULE_05 - Lockout suppresses word pulse to peripheral processor
// RULE_06 - Three ranks, one rank per clock
// RULE_07 - Last rank held on data until resume
// RULE_08 - Internal resume immediately while rank space remains
// RULE_09 - Internal resume: next slice, address, word pulse
// RULE_10 - Three words held: internal resume withheld
// RULE_11 - Processor resume: last rank reloads, internal resume
// RULE_12 - Processor accepts word, returns one resume
// RULE_13 - After fifth slice, request next memory word
// RULE_14 - Idle until memory word arrives, then repeat
// RULE_15 - Processor resume used without resynchronisation
// RULE_16 - Threshold interrupts as on normal channel
// RULE_17 - Interrupt request at half and end of buffer
// RULE_18 - Unclosed request: hold back, lock out output
// RULE_19 - Memory request held until memory accepts
// RULE_20 - Record pulse only for first word
//
// Decided for this implementation: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none

module hs_out_chan #(
	parameter int AW = 18
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Central memory read port
	output logic mem_req,
	output logic [AW-1:0] mem_addr,
	input wire logic mem_ack,
	input wire logic [hs_out_pkg::WORD_W-1:0] mem_rdata,
	// Peripheral processor channel
	output logic [hs_out_pkg::SLICE_W-1:0] pp_data,
	output logic pp_word,
	output logic pp_record,
	input wire logic pp_resume,
	// Interrupt request to the central processor
	output logic cpu_irq
);

	// ****************************************
	// Elaboration check
	// ****************************************
	if (AW < 2 || AW > 32) begin : g_bad_aw
		$error("AW out of range");
	end

	// ****************************************
	// Declarations
	// ****************************************
	hs_out_pkg::occ_state_t state;
	logic [AW-1:0] start_addr, buf_len, buf_addr;
	logic [hs_out_pkg::WORD_W-1:0] dis_reg;
	logic [2:0] dis_cnt;
	logic [hs_out_pkg::SLICE_W-1:0] rank_a, rank_b;
	logic first_word, va, vb, vc, pend, lockout;
	logic [1:0] occupancy;
	logic take_c, take_b, a_free, word_p, int_resume, thresh;
	logic bus_hit, cmd_reset, cmd_exit;
	logic [AW-1:0] next_addr, half_addr, end_addr;

	function automatic logic [AW-1:0] merge(input logic [AW-1:0] old,
		input logic [31:0] wd, input logic [3:0] sel);
		logic [31:0] m;
		m = 32'h0000_0000;
		for (int i = 0; i < 4; i++) begin
			m[i*8 +: 8] = sel[i] ? wd[i*8 +: 8] : 8'(32'(old) >> (i*8));
		end
		return m[AW-1:0];
	endfunction : merge

	// ****************************************
	// Wishbone slave
	// ****************************************
	assign bus_hit = cyc_i && stb_i && !ack_o;
	assign cmd_reset = bus_hit && we_i && adr_i == hs_out_pkg::CTRL_OFS && sel_i[0]
		&& dat_i[hs_out_pkg::CMD_RESET_BIT];
	assign cmd_exit = bus_hit && we_i && adr_i == hs_out_pkg::CTRL_OFS && sel_i[0]
		&& dat_i[hs_out_pkg::CMD_EXIT_BIT];

	always_ff @(posedge mclk) begin
		if (rst) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= bus_hit;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			start_addr <= hs_out_pkg::START_RST[AW-1:0];
			buf_len <= hs_out_pkg::LEN_RST[AW-1:0];
		end else if (bus_hit && we_i) begin
			if (adr_i == hs_out_pkg::START_OFS) begin
				start_addr <= merge(start_addr, dat_i, sel_i);
			end
			if (adr_i == hs_out_pkg::LEN_OFS) begin
				buf_len <= merge(buf_len, dat_i, sel_i);
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			dat_o <= 32'h0000_0000;
		end else begin
			dat_o <= 32'h0000_0000;
			if (bus_hit && !we_i) begin
				unique case (adr_i)
					hs_out_pkg::CTRL_OFS: begin
						dat_o[hs_out_pkg::ST_IRQ_BIT] <= cpu_irq;
						dat_o[hs_out_pkg::ST_LOCK_BIT] <= lockout;
						dat_o[hs_out_pkg::ST_BUSY_BIT] <= state != hs_out_pkg::ST_IDLE;
						dat_o[hs_out_pkg::ST_FETCH_BIT] <= mem_req;
					end
					hs_out_pkg::START_OFS: dat_o <= 32'(start_addr);
					hs_out_pkg::LEN_OFS: dat_o <= 32'(buf_len);
					hs_out_pkg::ADDR_OFS: dat_o <= 32'(buf_addr);
					default: dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ****************************************
	// Rank chain and high-speed buffer control
	// ****************************************
	assign occupancy = {1'b0, va} + {1'b0, vb} + {1'b0, vc};
	// Processor resume taken as is, no synchroniser
	assign take_c = vb && (!vc || pp_resume); // RULE_15 RULE_11
	assign take_b = va && (!vb || take_c); // RULE_06
	assign a_free = !va || take_b;
	assign int_resume = pend && occupancy < hs_out_pkg::RANKS && a_free; // RULE_08 RULE_10 RULE_11
	assign word_p = state == hs_out_pkg::ST_LOAD && !pend && !lockout && a_free;

	always_ff @(posedge mclk) begin
		if (rst || cmd_reset) begin
			va <= 1'b0;
			vb <= 1'b0;
			vc <= 1'b0;
			rank_a <= '0;
			rank_b <= '0;
			pp_data <= '0;
		end else begin
			if (word_p) begin
				rank_a <= dis_reg[hs_out_pkg::WORD_W-1 -: hs_out_pkg::SLICE_W]; // RULE_04
			end
			va <= word_p || (va && !take_b);
			if (take_b) begin
				rank_b <= rank_a; // RULE_06
			end
			vb <= take_b || (vb && !take_c);
			if (take_c) begin
				pp_data <= rank_b; // RULE_07 RULE_11
			end else if (vc && pp_resume) begin
				pp_data <= '0;
			end
			vc <= take_c || (vc && !pp_resume);
		end
	end

	always_ff @(posedge mclk) begin
		if (rst || cmd_reset) begin
			pend <= 1'b0;
		end else begin
			pend <= word_p || (pend && !int_resume);
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			pp_word <= 1'b0;
		end else begin
			pp_word <= word_p && !lockout; // RULE_04 RULE_05
		end
	end

	// ****************************************
	// Output channel control
	// ****************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			state <= hs_out_pkg::ST_IDLE;
			mem_req <= 1'b0;
			mem_addr <= '0;
			dis_reg <= '0;
			dis_cnt <= 3'h0;
			first_word <= 1'b0;
			pp_record <= 1'b0;
		end else if (cmd_reset) begin
			state <= hs_out_pkg::ST_FETCH;
			mem_req <= 1'b1; // RULE_01
			mem_addr <= start_addr;
			first_word <= 1'b1;
			pp_record <= 1'b0;
		end else begin
			pp_record <= 1'b0;
			unique case (state)
				hs_out_pkg::ST_IDLE: ;
				hs_out_pkg::ST_FETCH: begin
					if (mem_ack) begin
						dis_reg <= mem_rdata; // RULE_01 RULE_14
						dis_cnt <= 3'h0; // RULE_02
						mem_req <= 1'b0; // RULE_19
						pp_record <= first_word; // RULE_02 RULE_03 RULE_20
						first_word <= 1'b0;
						state <= hs_out_pkg::ST_LOAD;
					end
				end
				hs_out_pkg::ST_LOAD: begin
					if (word_p && dis_cnt == hs_out_pkg::LAST_SLICE) begin
						mem_req <= 1'b1; // RULE_13
						mem_addr <= buf_addr;
						state <= hs_out_pkg::ST_FETCH;
					end else if (word_p) begin
						state <= hs_out_pkg::ST_WAIT;
					end
				end
				hs_out_pkg::ST_WAIT: begin
					if (int_resume) begin
						dis_cnt <= dis_cnt + 3'h1; // RULE_09
						dis_reg <= dis_reg << hs_out_pkg::SLICE_W;
						state <= hs_out_pkg::ST_LOAD;
					end
				end
			endcase
		end
	end

	// ****************************************
	// Buffer address and threshold interrupts
	// ****************************************
	assign half_addr = start_addr + (buf_len >> 1);
	assign end_addr = start_addr + buf_len;
	assign next_addr = (buf_addr + 1'b1 == end_addr) ? start_addr : buf_addr + 1'b1;
	assign thresh = state == hs_out_pkg::ST_WAIT && int_resume && dis_cnt == 3'h0
		&& (next_addr == half_addr || next_addr == start_addr); // RULE_17

	always_ff @(posedge mclk) begin
		if (rst) begin
			buf_addr <= '0;
		end else if (cmd_reset) begin
			buf_addr <= start_addr; // RULE_01
		end else if (state == hs_out_pkg::ST_WAIT && int_resume && dis_cnt == 3'h0) begin
			buf_addr <= next_addr; // RULE_09
		end
	end

	// Same handling as a normal channel; a new event wins over an exit
	always_ff @(posedge mclk) begin
		if (rst || cmd_reset) begin
			cpu_irq <= 1'b0;
			lockout <= 1'b0;
		end else if (thresh) begin
			if (cpu_irq && !cmd_exit) begin
				lockout <= 1'b1; // RULE_16 RULE_18
			end else begin
				cpu_irq <= 1'b1; // RULE_16 RULE_17
			end
		end else if (cmd_exit) begin
			cpu_irq <= lockout; // RULE_18
			lockout <= 1'b0;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	property p_req_hold;
		@(posedge mclk) disable iff (rst || cmd_reset) mem_req && !mem_ack |=> mem_req;
	endproperty
	a_req_hold: assert property (p_req_hold) else $error("request dropped"); // RULE_19
	property p_data_hold;
		@(posedge mclk) disable iff (rst || cmd_reset) vc && !pp_resume |=> $stable(pp_data);
	endproperty
	a_data_hold: assert property (p_data_hold) else $error("rank C changed"); // RULE_07
	property p_lock_word;
		@(posedge mclk) disable iff (rst) lockout |=> !pp_word;
	endproperty
	a_lock_word: assert property (p_lock_word) else $error("word under lockout"); // RULE_05
	property p_full_stall;
		@(posedge mclk) disable iff (rst || cmd_reset)
			va && vb && vc && state == hs_out_pkg::ST_WAIT |=> state == hs_out_pkg::ST_WAIT;
	endproperty
	a_full_stall: assert property (p_full_stall) else $error("resume with ranks full"); // RULE_10
	property p_record;
		@(posedge mclk) disable iff (rst || cmd_reset)
			state == hs_out_pkg::ST_FETCH && mem_ack |=> pp_record == $past(first_word);
	endproperty
	a_record: assert property (p_record) else $error("record pulse wrong"); // RULE_20
	property p_shift;
		@(posedge mclk) disable iff (rst || cmd_reset) va && !vb |=> vb ##1 (vc || vb);
	endproperty
	a_shift: assert property (p_shift) else $error("rank did not advance"); // RULE_06
	property p_arrive;
		@(posedge mclk) disable iff (rst || cmd_reset) state == hs_out_pkg::ST_FETCH && mem_ack
			|=> dis_cnt == 3'h0 && state == hs_out_pkg::ST_LOAD && !mem_req;
	endproperty
	a_arrive: assert property (p_arrive) else $error("arrival handling wrong"); // RULE_02
	property p_fifth;
		@(posedge mclk) disable iff (rst || cmd_reset)
			word_p && dis_cnt == hs_out_pkg::LAST_SLICE |=> mem_req && mem_addr == $past(buf_addr);
	endproperty
	a_fifth: assert property (p_fifth) else $error("no request after fifth"); // RULE_13
	property p_reload;
		@(posedge mclk) disable iff (rst || cmd_reset)
			vc && vb && pp_resume |=> vc && pp_data == $past(rank_b);
	endproperty
	a_reload: assert property (p_reload) else $error("rank C not reloaded"); // RULE_11
	property p_word_fwd;
		@(posedge mclk) disable iff (rst || cmd_reset) word_p
			|=> pp_word && rank_a == $past(dis_reg[hs_out_pkg::WORD_W-1 -: hs_out_pkg::SLICE_W]);
	endproperty
	a_word_fwd: assert property (p_word_fwd) else $error("word pulse not forwarded"); // RULE_04
	property p_irq;
		@(posedge mclk) disable iff (rst || cmd_reset) thresh && !cpu_irq |=> cpu_irq;
	endproperty
	a_irq: assert property (p_irq) else $error("threshold request lost"); // RULE_17

endmodule : hs_out_chan

`default_nettype wire

// >>> pp_model.sv
// Peripheral processor model at the far end of the output channel
`timescale 1ns/1ps
`default_nettype none

module pp_model (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Channel from the multiplexer
	input wire logic [hs_out_pkg::SLICE_W-1:0] pp_data,
	input wire logic pp_word,
	output logic pp_resume
);
	logic [hs_out_pkg::SLICE_W-1:0] got[$];
	int pending;
	int since_word;
	int gap;

	// ****************************************
	// Accept each word, one resume per word
	// ****************************************
	always @(posedge mclk) begin
		if (rst) begin
			pending <= 0;
			since_word <= 0;
			gap <= 0;
			pp_resume <= 1'b0;
		end else begin
			if (pp_resume) begin
				got.push_back(pp_data);
			end
			since_word <= pp_word ? 0 : since_word + 1;
			pending <= pending + int'(pp_word) - int'(pp_resume);
			if (!pp_resume && pending > 0 && since_word >= 3 && gap == 0) begin
				pp_resume <= 1'b1;
				gap <= 1 + int'($urandom % 4);
			end else begin
				pp_resume <= 1'b0;
				if (gap > 0) begin
					gap <= gap - 1;
				end
			end
		end
	end
endmodule : pp_model

`default_nettype wire

// >>> tb_high_speed_output_channel.sv
// Testbench of the high-speed output channel
`timescale 1ns/1ps
`default_nettype none

module tb_high_speed_output_channel;
	logic mclk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] dat = 32'h0, dat_o, q;
	logic ack_o, mem_req, mem_ack = 1'b0, pp_word, pp_record, pp_resume, cpu_irq;
	logic [17:0] mem_addr, exp_addr;
	logic [59:0] mem_rdata = 60'h0;
	logic [11:0] pp_data, exp_q[$];
	int n_mismatch = 0, check_count = 0, rec = 0, n0;

	hs_out_chan uut (.mclk(mclk), .rst(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
		.sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .mem_req(mem_req),
		.mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .pp_data(pp_data),
		.pp_word(pp_word), .pp_record(pp_record), .pp_resume(pp_resume), .cpu_irq(cpu_irq));
	pp_model pp (.mclk(mclk), .rst(rst), .pp_data(pp_data), .pp_word(pp_word),
		.pp_resume(pp_resume));

	initial begin
		forever #10 mclk = ~mclk;
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	task chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= 4'hF;
		do begin
			@(posedge mclk);
		end while (ack_o !== 1'b1);
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb

	task wait_got(input int n);
		int k;
		for (k = 0; k < 20000 && pp.got.size() < n; k++) @(posedge mclk);
		if (pp.got.size() < n) n_mismatch++;
	endtask : wait_got

	task wrap_up;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : wrap_up

	// ****************************************
	// Central memory model, random wait
	// ****************************************
	always @(posedge mclk) begin
		if (pp_record === 1'b1) rec++;
		if (mem_req && !mem_ack && ($urandom % 4 == 0)) begin
			mem_rdata <= 60'({$urandom, $urandom});
			mem_ack <= 1'b1;
			chk("mem_addr", mem_addr, exp_addr);
			exp_addr = (exp_addr == 18'h13) ? 18'h10 : exp_addr + 18'h1;
		end else begin
			mem_ack <= 1'b0;
		end
		if (mem_ack) begin
			for (int i = 4; i >= 0; i--) exp_q.push_back(mem_rdata[i*12 +: 12]);
		end
	end

	initial begin
		#(20 * 60000);
		n_mismatch++;
		wrap_up();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		void'($urandom(32'h599F));
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		wb(0, hs_out_pkg::START_OFS, 32'h0);
		chk("start", q, hs_out_pkg::START_RST);
		wb(0, hs_out_pkg::LEN_OFS, 32'h0);
		chk("len", q, hs_out_pkg::LEN_RST);
		wb(0, 8'h10, 32'h0);
		chk("unmapped", q, 64'h0);
		wb(1, hs_out_pkg::START_OFS, 32'h10);
		wb(1, hs_out_pkg::LEN_OFS, 32'h4);
		wb(0, hs_out_pkg::START_OFS, 32'h0);
		chk("start written", q, 64'h10);
		wb(0, hs_out_pkg::LEN_OFS, 32'h0);
		chk("len written", q, 64'h4);
		exp_addr = 18'h10;
		wb(1, hs_out_pkg::CTRL_OFS, 32'h1 << hs_out_pkg::CMD_RESET_BIT);
		wb(0, hs_out_pkg::CTRL_OFS, 32'h0);
		chk("busy", q[hs_out_pkg::ST_BUSY_BIT], 64'h1);
		wait_got(10);
		for (int i = 0; i < 10; i++) chk("slice", pp.got[i], exp_q[i]);
		chk("record", rec, 64'h1);
		chk("irq half", cpu_irq, 64'h1);
		wb(1, hs_out_pkg::CTRL_OFS, 32'h1 << hs_out_pkg::CMD_EXIT_BIT);
		repeat (2) @(posedge mclk);
		chk("irq exit", cpu_irq, 64'h0);
		wait_got(20);
		for (int i = 10; i < 20; i++) chk("slice", pp.got[i], exp_q[i]);
		chk("irq end", cpu_irq, 64'h1);
		repeat (300) @(posedge mclk);
		wb(0, hs_out_pkg::CTRL_OFS, 32'h0);
		chk("lockout", q[hs_out_pkg::ST_LOCK_BIT], 64'h1);
		n0 = pp.got.size();
		repeat (100) @(posedge mclk);
		chk("stalled", pp.got.size(), n0);
		wb(0, hs_out_pkg::ADDR_OFS, 32'h0);
		chk("addr held", q, 64'h12);
		wb(1, hs_out_pkg::CTRL_OFS, 32'h1 << hs_out_pkg::CMD_EXIT_BIT);
		repeat (2) @(posedge mclk);
		chk("irq held", cpu_irq, 64'h1);
		wb(0, hs_out_pkg::CTRL_OFS, 32'h0);
		chk("unlocked", q[hs_out_pkg::ST_LOCK_BIT], 64'h0);
		wait_got(n0 + 5);
		chk("resumed", pp.got.size() >= n0 + 5, 64'h1);
		chk("record once", rec, 64'h1);
		wrap_up();
	end
endmodule : tb_high_speed_output_channel

`default_nettype wire
